// File: src/rsd_top.sv
// Single-step division datapath with accumulator pair
// Summary of operation
// - One step serves signed and unsigned division
// - Shift high/low accumulator pair left one
// - Accumulator extended with dividend sign flag
// - Divisor extended with divisor sign flag
// - Sign flags choose operation and commit test
// - Top result bit decides the commit
// - Both positive: subtract, commit on zero
// - Negative dividend: add, commit on one
// - Negative divisor: add, commit on zero
// - Both negative: subtract, commit on one
// - Commit loads high, sets low bit
// - No commit keeps shifted accumulators
// - Unsigned result: quotient low, remainder high
// - Each step takes one clock cycle
// - Without multiplier option step is no-op
`timescale 1ns/10ps
module rsd_top #(
  parameter bit HAS_MULT = 1'b1
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        step_divide_op_i,
  input  wire logic [31:0] source_operand_reg_i,
  input  wire logic        dividend_sign_flag_i,
  input  wire logic        divisor_sign_flag_i,
  input  wire logic        acc_load_i,
  input  wire logic [31:0] acc_high_load_i,
  input  wire logic [31:0] acc_low_load_i,
  output logic      [31:0] acc_high_o,
  output logic      [31:0] acc_low_o,
  output logic             step_done_o
);

  logic [31:0] acc_high_r;
  logic [31:0] acc_high_nxt;
  logic [31:0] acc_low_r;
  logic [31:0] acc_low_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [31:0] sh_high;
  logic [31:0] sh_low;
  logic        step_en;

  rsd_step_if st ();

  // ****************************************
  // Shift and step operands
  // ****************************************
  assign step_en = step_divide_op_i & HAS_MULT;
  assign sh_high = {acc_high_r[30:0], acc_low_r[31]};
  assign sh_low  = {acc_low_r[30:0], 1'b0};
  assign st.acc_high           = sh_high;
  assign st.divisor            = source_operand_reg_i;
  assign st.dividend_sign_flag = dividend_sign_flag_i;
  assign st.divisor_sign_flag  = divisor_sign_flag_i;

  rsd_alu u_alu (
    .st (st.alu)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    acc_high_nxt = acc_high_r;
    acc_low_nxt  = acc_low_r;
    done_nxt     = 1'b0;
    if (acc_load_i) begin
      acc_high_nxt = acc_high_load_i;
      acc_low_nxt  = acc_low_load_i;
    end else if (step_en) begin
      done_nxt = 1'b1;
      if (st.commit) begin
        acc_high_nxt = st.res_high;
        acc_low_nxt  = {sh_low[31:1], 1'b1};
      end else begin
        acc_high_nxt = sh_high;
        acc_low_nxt  = sh_low;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_high_r <= rsd_pkg::ACC_RST;
      acc_low_r  <= rsd_pkg::ACC_RST;
      done_r     <= 1'b0;
    end else begin
      acc_high_r <= acc_high_nxt;
      acc_low_r  <= acc_low_nxt;
      done_r     <= done_nxt;
    end
  end

  assign acc_high_o  = acc_high_r;
  assign acc_low_o   = acc_low_r;
  assign step_done_o = done_r;

  // ****************************************
  // Assertion helpers
  // ****************************************
  logic        step_tk;
  logic [32:0] chk_sum;
  logic [32:0] chk_dif;

  assign step_tk = step_en & ~acc_load_i;
  assign chk_sum = {1'b0, sh_high} + {1'b0, source_operand_reg_i};
  assign chk_dif = {1'b0, sh_high} - {1'b0, source_operand_reg_i};

  // ****************************************
  // Shift checks
  // ****************************************
  a_shift_low_bit: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    step_tk
    |=>
    (acc_low_r[31:1] == $past(acc_low_r[30:0]))
  ) else $error("low accumulator not shifted");

  a_shift_high: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (step_tk && !st.commit)
    |=>
    (acc_high_r == {$past(acc_high_r[30:0]), $past(acc_low_r[31])})
  ) else $error("high accumulator not shifted");

  a_commit_bit: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    step_tk
    |=>
    (acc_low_r[0] == $past(st.commit))
  ) else $error("quotient bit wrong");

  a_low_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (step_tk && !st.commit)
    |=>
    !acc_low_r[0]
  ) else $error("shifted in bit not zero");

  // ****************************************
  // Operand extension and top-bit commit
  // ****************************************
  a_ext_dividend: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (u_alu.a_ext == {dividend_sign_flag_i, sh_high})
  ) else $error("accumulator extension wrong");

  a_ext_divisor: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (u_alu.b_ext == {divisor_sign_flag_i, source_operand_reg_i})
  ) else $error("divisor extension wrong");

  a_top_decides: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (st.commit == (u_alu.tmp[32] == dividend_sign_flag_i))
  ) else $error("commit not from top bit");

  // ****************************************
  // Sign cases
  // ****************************************
  a_pp_case: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!dividend_sign_flag_i && !divisor_sign_flag_i)
    |->
    (st.commit == !chk_dif[32])
  ) else $error("unsigned commit wrong");

  a_pp_result: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!dividend_sign_flag_i && !divisor_sign_flag_i)
    |->
    (st.res_high == chk_dif[31:0])
  ) else $error("unsigned difference wrong");

  a_np_case: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (dividend_sign_flag_i && !divisor_sign_flag_i)
    |->
    (st.commit == !chk_sum[32])
  ) else $error("negative dividend commit wrong");

  a_np_result: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (dividend_sign_flag_i && !divisor_sign_flag_i)
    |->
    (st.res_high == chk_sum[31:0])
  ) else $error("negative dividend sum wrong");

  a_pn_case: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!dividend_sign_flag_i && divisor_sign_flag_i)
    |->
    (st.commit == chk_sum[32])
  ) else $error("negative divisor commit wrong");

  a_pn_result: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!dividend_sign_flag_i && divisor_sign_flag_i)
    |->
    (st.res_high == chk_sum[31:0])
  ) else $error("negative divisor sum wrong");

  a_nn_case: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (dividend_sign_flag_i && divisor_sign_flag_i)
    |->
    (st.commit == (sh_high < source_operand_reg_i))
  ) else $error("negative pair commit wrong");

  a_nn_result: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (dividend_sign_flag_i && divisor_sign_flag_i)
    |->
    (st.res_high == chk_dif[31:0])
  ) else $error("negative pair difference wrong");

  // ****************************************
  // Commit checks
  // ****************************************
  a_commit_high: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (step_tk && st.commit)
    |=>
    (acc_high_r == $past(st.res_high))
  ) else $error("high accumulator not committed");

  a_commit_low: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (step_tk && st.commit)
    |=>
    acc_low_r[0]
  ) else $error("quotient bit not set");

  a_keep_shift: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (step_tk && !st.commit)
    |=>
    (acc_high_r == $past(sh_high))
  ) else $error("shifted high not kept");

  // ****************************************
  // Timing and load checks
  // ****************************************
  a_one_cycle: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    step_tk
    |=>
    step_done_o ##1 (step_done_o == $past(step_tk))
  ) else $error("step not done in one cycle");

  a_done_cause: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    step_done_o
    |->
    $past(step_tk)
  ) else $error("done without a step");

  a_load_value: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    acc_load_i
    |=>
    (acc_high_r == $past(acc_high_load_i) &&
     acc_low_r == $past(acc_low_load_i))
  ) else $error("accumulators not loaded");

  a_load_no_done: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    acc_load_i
    |=>
    !step_done_o
  ) else $error("done after a load");

  // ****************************************
  // No multiplier option
  // ****************************************
  a_nop_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!step_en && !acc_load_i)
    |=>
    ($stable(acc_high_r) && $stable(acc_low_r) && !step_done_o)
  ) else $error("state changed without step");

  a_nomul_quiet: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    !HAS_MULT
    |->
    !step_done_o
  ) else $error("done pulse without multiplier");

  a_nomul_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rstn_i)
    (!HAS_MULT && !acc_load_i)
    |=>
    ($stable(acc_high_r) && $stable(acc_low_r))
  ) else $error("state changed without multiplier");

endmodule // rsd_top

// File: src/rsd_pkg.sv
// Package of constants for the restoring step divider
package rsd_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EXT_W  = 33;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] ACC_RST = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned STEP_CYCLES = 1;

  // ****************************************
  // Sign cases
  // ****************************************
  localparam logic [1:0] CASE_PP = 2'h0;
  localparam logic [1:0] CASE_PN = 2'h1;
  localparam logic [1:0] CASE_NP = 2'h2;
  localparam logic [1:0] CASE_NN = 2'h3;

endpackage

// File: src/rsd_step_if.sv
// Interface carrying one step's operands and result
`timescale 1ns/10ps
interface rsd_step_if;
  logic [31:0] acc_high;
  logic [31:0] divisor;
  logic        dividend_sign_flag;
  logic        divisor_sign_flag;
  logic [31:0] res_high;
  logic        commit;

  modport core (output acc_high, divisor, dividend_sign_flag,
                divisor_sign_flag, input res_high, commit);
  modport alu  (input acc_high, divisor, dividend_sign_flag,
                divisor_sign_flag, output res_high, commit);
endinterface

// File: src/rsd_ext.sv
// Sign extender to 33 bits with a flag as top bit
`timescale 1ns/10ps
module rsd_ext (
  input  wire logic        flag_i,
  input  wire logic [31:0] val_i,
  output logic      [32:0] ext_o
);
  assign ext_o = {flag_i, val_i};
endmodule // rsd_ext

// File: src/rsd_alu.sv
// Add or subtract stage and commit decision of one step
`timescale 1ns/10ps
module rsd_alu (
  rsd_step_if.alu st
);
  logic [32:0] a_ext;
  logic [32:0] b_ext;
  logic [32:0] tmp;

  // ****************************************
  // Operand extension
  // ****************************************
  rsd_ext u_ext_a (
    .flag_i (st.dividend_sign_flag),
    .val_i  (st.acc_high),
    .ext_o  (a_ext)
  );
  rsd_ext u_ext_b (
    .flag_i (st.divisor_sign_flag),
    .val_i  (st.divisor),
    .ext_o  (b_ext)
  );

  // ****************************************
  // Arithmetic and commit
  // ****************************************
  always_comb begin
    tmp       = 33'h0_0000_0000;
    st.commit = 1'b0;
    case ({st.dividend_sign_flag, st.divisor_sign_flag})
      rsd_pkg::CASE_PP: begin
        tmp       = a_ext - b_ext;
        st.commit = ~tmp[32];
      end
      rsd_pkg::CASE_PN: begin
        tmp       = a_ext + b_ext;
        st.commit = ~tmp[32];
      end
      rsd_pkg::CASE_NP: begin
        tmp       = a_ext + b_ext;
        st.commit = tmp[32];
      end
      rsd_pkg::CASE_NN: begin
        tmp       = a_ext - b_ext;
        st.commit = tmp[32];
      end
      default: begin
        tmp       = 33'h0_0000_0000;
        st.commit = 1'b0;
      end
    endcase
  end
  assign st.res_high = tmp[31:0];
endmodule // rsd_alu

// File: bench/rsd_core_model.sv
// Issue model of the decode stage and register file
`timescale 1ns/10ps
module rsd_core_model (
  input  wire logic        clk_i,
  output logic             step_o,
  output logic             load_o,
  output logic [31:0]      source_operand_reg_o,
  output logic             dividend_sign_flag_o,
  output logic             divisor_sign_flag_o,
  output logic [31:0]      hi_o,
  output logic [31:0]      lo_o
);
  initial {step_o, load_o, source_operand_reg_o} = '0;
  initial {dividend_sign_flag_o, divisor_sign_flag_o, hi_o, lo_o} = '0;
  // ************************************
  // Drive one cycle, called at falling edge
  // ************************************
  task automatic issue(input logic s, input logic l, input logic [31:0] r,
    input logic d, input logic n, input logic [31:0] h, input logic [31:0] o);
    step_o = s;
    load_o = l;
    source_operand_reg_o = s ? r : ~source_operand_reg_o;
    dividend_sign_flag_o = d;
    divisor_sign_flag_o  = n;
    hi_o   = l ? h : ~hi_o;
    lo_o   = l ? o : ~lo_o;
  endtask
endmodule // rsd_core_model

// File: bench/testbench.sv
// Self-checking bench of the step divider
`timescale 1ns/10ps
module testbench;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        st, ld, dvd_neg, n, dn, bd, ed;
  logic [31:0] dvr, hh, ll, ah, al, bh, bl, eh, el, fh, fl, dvd, dvs;
  int          errors = 0;
  int          total_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  rsd_core_model u_core (.clk_i(sys_clk_i), .step_o(st), .load_o(ld),
    .source_operand_reg_o(dvr), .dividend_sign_flag_o(dvd_neg),
    .divisor_sign_flag_o(n), .hi_o(hh), .lo_o(ll));
  rsd_top u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .step_divide_op_i(st), .source_operand_reg_i(dvr),
    .dividend_sign_flag_i(dvd_neg), .divisor_sign_flag_i(n), .acc_load_i(ld),
    .acc_high_load_i(hh), .acc_low_load_i(ll), .acc_high_o(ah),
    .acc_low_o(al), .step_done_o(dn));
  rsd_top #(.HAS_MULT(1'b0)) u_nomul (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .step_divide_op_i(st), .source_operand_reg_i(dvr),
    .dividend_sign_flag_i(dvd_neg), .divisor_sign_flag_i(n), .acc_load_i(ld),
    .acc_high_load_i(hh), .acc_low_load_i(ll), .acc_high_o(bh),
    .acc_low_o(bl), .step_done_o(bd));
  // ************************************
  // Reference and checks
  // ************************************
  function automatic logic [63:0] ref_step(input logic [31:0] h,
    input logic [31:0] l, input logic [31:0] r, input logic d, input logic m);
    logic [63:0] s;
    logic [32:0] t;
    s = {h, l} << 1;
    t = (d == m) ? {d, s[63:32]} - {m, r} : {d, s[63:32]} + {m, r};
    if (t[32] == d) s = {t[31:0], s[31:1], 1'b1};
    return s;
  endfunction
  function automatic logic [31:0] sign_fix(input logic [31:0] q,
    input logic d, input logic m);
    return (d != m) ? -q : q;
  endfunction
  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input logic s, input logic l, input logic [31:0] r,
    input logic d, input logic m, input logic [31:0] h, input logic [31:0] o);
    @(negedge sys_clk_i);
    cmp(ah, eh);
    cmp(al, el);
    cmp_bit(dn, ed);
    cmp(bh, fh);
    cmp(bl, fl);
    cmp_bit(bd, 1'b0);
    u_core.issue(s, l, r, d, m, h, o);
    ed = s & ~l;
    if (l) {eh, el, fh, fl} = {h, o, h, o};
    else if (s) {eh, el} = ref_step(eh, el, r, d, m);
  endtask
  task automatic run_div(input logic [31:0] a, input logic [31:0] b,
    input logic d, input logic m);
    cyc(1'b0, 1'b1, 32'h0, d, m, 32'h0, a);
    repeat (32) cyc(1'b1, 1'b0, b, d, m, 32'h0, 32'h0);
    cyc(1'b0, 1'b0, 32'h0, d, m, 32'h0, 32'h0);
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    {eh, el, fh, fl, ed} = '0;
    void'($urandom(32'h293bc172));
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rstn_i = 1'b1;
    cyc(1'b0, 1'b1, 32'h0, 1'b0, 1'b0, $urandom, $urandom);
    for (int k = 0; k < 4; k++) begin
      cyc(1'b1, 1'b0, $urandom, k[1], k[0], 32'h0, 32'h0);
    end
    cyc(1'b1, 1'b1, $urandom, 1'b0, 1'b0, $urandom, $urandom);
    for (int k = 0; k < 3; k++) begin
      dvd = (k == 0) ? 32'hffff_ffff : $urandom;
      dvs = (k == 0) ? 32'h0000_0001 : $urandom_range(1, 32'h0001_ffff);
      run_div(dvd, dvs, 1'b0, 1'b0);
      cmp(al, dvd / dvs);
      cmp(ah, dvd % dvs);
    end
    dvd = $urandom & 32'h7fff_ffff;
    dvs = $urandom | 32'h8000_0000;
    run_div(dvd, dvs, 1'b0, 1'b1);
    cmp(sign_fix(al, 1'b0, 1'b1), $signed(dvd) / $signed(dvs));
    cmp(ah, $signed(dvd) % $signed(dvs));
    repeat (300) begin
      cyc($urandom_range(0, 1), ($urandom % 8) == 0, $urandom,
        $urandom_range(0, 1), $urandom_range(0, 1), $urandom, $urandom);
    end
    cyc(1'b0, 1'b0, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
    tally_and_finish();
  end
  initial begin
    #(50 * 2000);
    errors++;
    tally_and_finish();
  end
endmodule // testbench
